// ### design/mrs_pkg.sv
// Shared constants and carriers for the memory reference sequencer
package mrs_pkg;
  // Word and nibble layout
  localparam int WORD_W = 16;
  localparam int NIB_W = 4;
  localparam int NIB_PER_WORD = 4;
  // Clock timing
  localparam int PCLK_NS = 50;
  localparam int CPU_CLK_NS = 150;
  localparam int CPU_DIV = CPU_CLK_NS / PCLK_NS;
  localparam int LOOP_EXT_NS = 600;
  localparam int LOOP_EXT_CLK = LOOP_EXT_NS / CPU_CLK_NS;
  localparam int WINDOW_CLK = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_OPERAND = 8'h0C;
  localparam logic [7:0] OFS_MADDR = 8'h10;
  localparam logic [7:0] OFS_OPCODE = 8'h14;
  localparam logic [7:0] OFS_RESULT = 8'h18;
  localparam logic [7:0] OFS_WREG0 = 8'h20;
  // Control bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_RUN = 1;
  localparam int CTRL_ZERO = 2;
  // Opcode field positions
  localparam int OP_HI = 15;
  localparam int OP_LO = 13;
  localparam int SEL_HI = 12;
  localparam int SEL_LO = 11;
  localparam int IND_BIT = 10;
  localparam int STB_HI = 10;
  localparam int STB_LO = 9;
  localparam int PAGE_HI = 9;
  localparam int PAGE_LO = 8;
  localparam int DISP_SIGN = 7;
  // Opcode classes
  localparam logic [2:0] OPC_JUMP = 3'h0;
  localparam logic [2:0] OPC_CALL = 3'h1;
  localparam logic [2:0] OPC_LOAD = 3'h2;
  localparam logic [2:0] OPC_STORE = 3'h3;
  localparam logic [2:0] OPC_IN = 3'h6;
  localparam logic [2:0] OPC_ALC = 3'h7;
  // Reset value and call working register
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] CALL_REG = 2'h3;

  typedef enum logic [3:0] {
    MRS_IDLE  = 4'b0001,
    MRS_FETCH = 4'b0010,
    MRS_DEFER = 4'b0100,
    MRS_EXEC  = 4'b1000
  } mrs_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic buffer_write_pulse;
    logic memory_driver_disable;
    logic io_bus_select;
  } mrs_mem_t;

  typedef struct packed {
    logic input_ctl;
    logic input_strobe_a;
    logic input_strobe_b;
    logic input_strobe_c;
    logic skip_test;
  } mrs_io_t;
endpackage

// ### design/mrs_sequencer.sv
// Memory reference sequencer with APB register access
// How it works
// - Execute start loads effective address into address
// - Loaded word copied to operand then rewritten
// - Load cycle opens eight-clock accumulator write window
// - Fetch increments operand into program counter nibblewise
// - Non-I/O, non-arithmetic fetch sets address phase
// - Store selects working register by bits 11-12
// - Execute slot three shifts counter into operand
// - Indirect jump fetch puts pointer in counter/operand
// - Defer reads pointer word, rewrites, loads counter
// - Call fetch sets window at end of slot two and call marker at fetch end
// - Pointer in 0010-001F sets loop flip-flop
// - Nibble gating with remembered failure detects autoindex
// - Autoindex hit updates pointer and writes back
// - Nibble pulse one latches increment/decrement direction
// - Input strobes start first clock after stutter
// - Input execute slot zero issues buffer write
// - Bus select steers buffer input to I/O
// - Driver disable turns off memory data drivers
// - Disabled bus loads zeros into operand register
// - Bits nine and ten choose input strobe
// - Loop stretches slot zero by four clocks
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module mrs_sequencer #(
  parameter int CPU_DIV = mrs_pkg::CPU_DIV
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core memory and I/O bus
  input wire logic [15:0] mem_rdata,
  output mrs_pkg::mrs_mem_t mem_o,
  output mrs_pkg::mrs_io_t io_o,
  // Observed sequencer state
  output logic accum_write_window,
  output logic effective_addr_phase,
  output logic call_marker_flag
);
  mrs_pkg::mrs_state_t state_r;
  logic [1:0] div_r;
  logic step;
  logic [1:0] ts_r, nib_r;
  logic loop_r;
  logic [15:0] operand_shift_reg, memory_address_reg, program_counter, opcode_latch;
  logic [15:0] result_holding_buffer;
  logic [15:0] working_register [0:3];
  logic [15:0] wdata_r;
  logic bwp_r, drv_dis_r, io_sel_r, carry_r, dir_r, fail_r;
  logic eap_r, call_r, win_r;
  logic [2:0] win_cnt_r;
  logic [1:0] win_reg_r;
  logic run_r, start_r, zero_r;
  logic in_ctl_r, stb_a_r, stb_b_r, stb_c_r, skip_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic [2:0] opc;
  logic memref, indirect, page0, is_idle, slot0, cyc_end;
  logic nib_bad, idx_hit, idx_phase, f_inc, f_ea;
  logic [3:0] add_a, add_b, disp_nib;
  logic add_c0;
  logic [4:0] sum;
  logic [31:0] rd_val;
  logic addr_ok, wr_acc;
  logic [15:0] mem_word;

  assign opc = opcode_latch[mrs_pkg::OP_HI:mrs_pkg::OP_LO];
  assign memref = (opc != mrs_pkg::OPC_IN) && (opc != mrs_pkg::OPC_ALC);
  assign indirect = opcode_latch[mrs_pkg::IND_BIT];
  assign page0 = (opcode_latch[mrs_pkg::PAGE_HI:mrs_pkg::PAGE_LO] == 2'h0);
  assign is_idle = (state_r == mrs_pkg::MRS_IDLE);
  assign slot0 = (ts_r == 2'h0) && !loop_r;
  assign cyc_end = step && (ts_r == 2'h3) && (nib_r == 2'h3);
  // Zeros appear while the memory drivers are off
  assign mem_word = drv_dis_r ? mrs_pkg::RST_WORD : mem_rdata;

  // Processor clock enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      step <= 1'b0;
    end else begin
      step <= (div_r == 2'(CPU_DIV - 1));
      div_r <= (div_r == 2'(CPU_DIV - 1)) ? 2'h0 : div_r + 2'h1;
    end
  end

  // Autoindex nibble gating, low nibble ignored, top bit masked
  always_comb begin
    case (nib_r)
      2'h1: nib_bad = (operand_shift_reg[7:4] != 4'h1);
      2'h2: nib_bad = (operand_shift_reg[11:8] != 4'h0);
      2'h3: nib_bad = (operand_shift_reg[14:12] != 3'h0);
      default: nib_bad = 1'b0;
    endcase
  end
  assign idx_hit = (state_r == mrs_pkg::MRS_DEFER) && slot0 && (nib_r == 2'h3)
    && !(fail_r || nib_bad);

  // Time states, nibble pulses and major states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= mrs_pkg::MRS_IDLE;
      ts_r <= 2'h0;
      nib_r <= 2'h0;
      loop_r <= 1'b0;
    end else if (is_idle) begin
      ts_r <= 2'h0;
      nib_r <= 2'h0;
      if (start_r)
        state_r <= mrs_pkg::MRS_FETCH;
    end else if (step) begin
      nib_r <= nib_r + 2'h1;
      if (idx_hit) begin
        loop_r <= 1'b1;
      end else if (nib_r == 2'h3 && loop_r) begin
        loop_r <= 1'b0;
        ts_r <= 2'h1;
      end else if (nib_r == 2'h3) begin
        ts_r <= ts_r + 2'h1;
      end
      if (cyc_end) begin
        case (state_r)
          mrs_pkg::MRS_FETCH:
            if (opc == mrs_pkg::OPC_IN)
              state_r <= mrs_pkg::MRS_EXEC;
            else if (memref && indirect)
              state_r <= mrs_pkg::MRS_DEFER;
            else if (opc == mrs_pkg::OPC_LOAD || opc == mrs_pkg::OPC_STORE)
              state_r <= mrs_pkg::MRS_EXEC;
            else
              state_r <= run_r ? mrs_pkg::MRS_FETCH : mrs_pkg::MRS_IDLE;
          mrs_pkg::MRS_DEFER:
            if (opc == mrs_pkg::OPC_LOAD || opc == mrs_pkg::OPC_STORE)
              state_r <= mrs_pkg::MRS_EXEC;
            else
              state_r <= run_r ? mrs_pkg::MRS_FETCH : mrs_pkg::MRS_IDLE;
          default:
            state_r <= run_r ? mrs_pkg::MRS_FETCH : mrs_pkg::MRS_IDLE;
        endcase
      end
    end
  end

  // Shared nibble adder
  always_comb begin
    case (nib_r)
      2'h0: disp_nib = opcode_latch[3:0];
      2'h1: disp_nib = opcode_latch[7:4];
      default: disp_nib = (!page0 && opcode_latch[mrs_pkg::DISP_SIGN]) ? 4'hF : 4'h0;
    endcase
    f_inc = (state_r == mrs_pkg::MRS_FETCH) && (ts_r == 2'h1);
    f_ea = (state_r == mrs_pkg::MRS_FETCH) && (ts_r == 2'h3) && memref;
    idx_phase = (state_r == mrs_pkg::MRS_DEFER) && loop_r;
    add_a = operand_shift_reg[3:0];
    add_b = 4'h0;
    add_c0 = 1'b0;
    if (f_inc) begin
      add_c0 = 1'b1;
    end else if (f_ea) begin
      add_a = page0 ? 4'h0 : operand_shift_reg[3:0];
      add_b = disp_nib;
    end else if (idx_phase) begin
      add_b = dir_r ? 4'h0 : 4'hF;
      add_c0 = dir_r;
    end
    sum = 5'({1'b0, add_a} + {1'b0, add_b} + 5'((nib_r == 2'h0) ? add_c0 : carry_r));
  end

  assign wr_acc = psel && penable && pready_r && pwrite && is_idle;

  // Datapath registers and memory strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand_shift_reg <= mrs_pkg::RST_WORD;
      memory_address_reg <= mrs_pkg::RST_WORD;
      program_counter <= mrs_pkg::RST_WORD;
      opcode_latch <= mrs_pkg::RST_WORD;
      result_holding_buffer <= mrs_pkg::RST_WORD;
      wdata_r <= mrs_pkg::RST_WORD;
      for (int i = 0; i < 4; i++)
        working_register[i] <= mrs_pkg::RST_WORD;
      bwp_r <= 1'b0;
      carry_r <= 1'b0;
      dir_r <= 1'b0;
      fail_r <= 1'b0;
    end else begin
      bwp_r <= 1'b0;
      // Fetch address comes from the operand, so keep it with the counter
      if (wr_acc && paddr == mrs_pkg::OFS_PC) begin
        program_counter <= pwdata[15:0];
        operand_shift_reg <= pwdata[15:0];
      end
      if (wr_acc && paddr[7:4] == mrs_pkg::OFS_WREG0[7:4] && paddr[1:0] == 2'h0)
        working_register[paddr[3:2]] <= pwdata[15:0];
      if (drv_dis_r && step)
        operand_shift_reg <= mem_word;
      // Window runs on into idle so the register write completes
      if (step) begin
        // First half fills result buffer, second half writes register
        if (win_r && !win_cnt_r[2])
          result_holding_buffer <= {state_r == mrs_pkg::MRS_FETCH ?
            program_counter[3:0] : operand_shift_reg[3:0],
            result_holding_buffer[15:4]};
        if (win_r && win_cnt_r[2]) begin
          result_holding_buffer <= {result_holding_buffer[3:0], result_holding_buffer[15:4]};
          working_register[win_reg_r] <= {result_holding_buffer[3:0],
            working_register[win_reg_r][15:4]};
        end
      end
      if (step && !is_idle) begin
        carry_r <= sum[4];
        if (slot0 && nib_r == 2'h0)
          memory_address_reg <= operand_shift_reg;
        case (state_r)
          mrs_pkg::MRS_FETCH: begin
            if (slot0 && nib_r == 2'h2) begin
              opcode_latch <= mem_word;
              wdata_r <= mem_word;
              bwp_r <= 1'b1;
            end
            if (ts_r == 2'h1) begin
              program_counter <= {sum[3:0], program_counter[15:4]};
              operand_shift_reg <= {operand_shift_reg[3:0], operand_shift_reg[15:4]};
            end
            if (ts_r == 2'h3 && memref) begin
              operand_shift_reg <= {sum[3:0], operand_shift_reg[15:4]};
              if (opc == mrs_pkg::OPC_JUMP || opc == mrs_pkg::OPC_CALL)
                program_counter <= {sum[3:0], program_counter[15:4]};
            end else if (ts_r == 2'h3) begin
              operand_shift_reg <= {program_counter[3:0], operand_shift_reg[15:4]};
              program_counter <= {program_counter[3:0], program_counter[15:4]};
            end
          end
          mrs_pkg::MRS_DEFER: begin
            fail_r <= ((nib_r == 2'h0) ? 1'b0 : fail_r) | nib_bad;
            if (slot0 && nib_r == 2'h1)
              dir_r <= operand_shift_reg[3];
            if (slot0 && nib_r == 2'h3)
              operand_shift_reg <= mem_word;
            if (loop_r)
              operand_shift_reg <= {sum[3:0], operand_shift_reg[15:4]};
            if (loop_r && !win_r)
              result_holding_buffer <= {sum[3:0], result_holding_buffer[15:4]};
            if (ts_r == 2'h1 && nib_r == 2'h0) begin
              wdata_r <= operand_shift_reg;
              bwp_r <= 1'b1;
            end
            if (ts_r == 2'h2) begin
              operand_shift_reg <= {operand_shift_reg[3:0], operand_shift_reg[15:4]};
              if (opc == mrs_pkg::OPC_JUMP || opc == mrs_pkg::OPC_CALL)
                program_counter <= {operand_shift_reg[3:0], program_counter[15:4]};
            end
          end
          mrs_pkg::MRS_EXEC: begin
            if (slot0 && nib_r == 2'h0 && opc == mrs_pkg::OPC_IN)
              bwp_r <= 1'b1;
            if (slot0 && nib_r == 2'h2 && opc != mrs_pkg::OPC_STORE)
              operand_shift_reg <= mem_word;
            if (slot0 && nib_r == 2'h3 && opc == mrs_pkg::OPC_LOAD) begin
              wdata_r <= operand_shift_reg;
              bwp_r <= 1'b1;
            end
            if (ts_r == 2'h1 && opc == mrs_pkg::OPC_STORE)
              operand_shift_reg <= {working_register[opcode_latch[mrs_pkg::SEL_HI:mrs_pkg::SEL_LO]]
                [4*nib_r +: 4], operand_shift_reg[15:4]};
            if (ts_r == 2'h2 && nib_r == 2'h0 && opc == mrs_pkg::OPC_STORE) begin
              wdata_r <= operand_shift_reg;
              bwp_r <= 1'b1;
            end
            if (ts_r == 2'h3) begin
              operand_shift_reg <= {program_counter[3:0], operand_shift_reg[15:4]};
              program_counter <= {program_counter[3:0], program_counter[15:4]};
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Phase flags and accumulator write window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eap_r <= 1'b0;
      call_r <= 1'b0;
      win_r <= 1'b0;
      win_cnt_r <= 3'h0;
      win_reg_r <= 2'h0;
    end else if (step) begin
      if (slot0 && nib_r == 2'h0 && state_r != mrs_pkg::MRS_FETCH)
        eap_r <= 1'b0;
      if (slot0 && nib_r == 2'h0 && state_r == mrs_pkg::MRS_FETCH)
        call_r <= 1'b0;
      if (cyc_end && state_r == mrs_pkg::MRS_FETCH && memref)
        eap_r <= 1'b1;
      if (cyc_end && state_r == mrs_pkg::MRS_FETCH && opc == mrs_pkg::OPC_CALL)
        call_r <= 1'b1;
      if (win_r)
        win_cnt_r <= win_cnt_r + 3'h1;
      if (win_r && win_cnt_r == 3'(mrs_pkg::WINDOW_CLK - 1))
        win_r <= 1'b0;
      // Window opens just before the final slot so its first half shifts with it
      if (ts_r == 2'h2 && nib_r == 2'h3 &&
          ((state_r == mrs_pkg::MRS_FETCH && opc == mrs_pkg::OPC_CALL) ||
           (state_r == mrs_pkg::MRS_EXEC && (opc == mrs_pkg::OPC_LOAD || opc == mrs_pkg::OPC_IN)))) begin
        win_r <= 1'b1;
        win_cnt_r <= 3'h0;
        win_reg_r <= (opc == mrs_pkg::OPC_CALL) ? mrs_pkg::CALL_REG :
          opcode_latch[mrs_pkg::SEL_HI:mrs_pkg::SEL_LO];
      end
    end
  end

  // I/O input control, strobes and bus select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_ctl_r <= 1'b0;
      io_sel_r <= 1'b0;
      {stb_a_r, stb_b_r, stb_c_r, skip_r} <= 4'h0;
      drv_dis_r <= 1'b0;
    end else begin
      if (step)
        drv_dis_r <= 1'b0;
      if (zero_r && is_idle)
        drv_dis_r <= 1'b1;
      if (step && state_r == mrs_pkg::MRS_FETCH && ts_r == 2'h2 && nib_r == 2'h0
          && opc == mrs_pkg::OPC_IN) begin
        in_ctl_r <= 1'b1;
        io_sel_r <= 1'b1;
        case (opcode_latch[mrs_pkg::STB_HI:mrs_pkg::STB_LO])
          2'h1: stb_a_r <= 1'b1;
          2'h2: stb_b_r <= 1'b1;
          2'h3: stb_c_r <= 1'b1;
          default: skip_r <= 1'b1;
        endcase
      end
      if (step && state_r == mrs_pkg::MRS_EXEC && slot0 && nib_r == 2'h1) begin
        in_ctl_r <= 1'b0;
        io_sel_r <= 1'b0;
        {stb_a_r, stb_b_r, stb_c_r, skip_r} <= 4'h0;
      end
    end
  end

  // APB slave, one wait-free access phase
  always_comb begin
    addr_ok = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      mrs_pkg::OFS_CTRL: rd_val = {29'h0, zero_r, run_r, start_r};
      mrs_pkg::OFS_STATUS: rd_val = {18'h0, in_ctl_r, dir_r, win_r, call_r, eap_r,
        loop_r, nib_r, ts_r, state_r};
      mrs_pkg::OFS_PC: rd_val = {16'h0, program_counter};
      mrs_pkg::OFS_OPERAND: rd_val = {16'h0, operand_shift_reg};
      mrs_pkg::OFS_MADDR: rd_val = {16'h0, memory_address_reg};
      mrs_pkg::OFS_OPCODE: rd_val = {16'h0, opcode_latch};
      mrs_pkg::OFS_RESULT: rd_val = {16'h0, result_holding_buffer};
      8'h20, 8'h24, 8'h28, 8'h2C: rd_val = {16'h0, working_register[paddr[3:2]]};
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      run_r <= 1'b0;
      start_r <= 1'b0;
      zero_r <= 1'b0;
    end else begin
      pready_r <= psel && !penable && !pready_r;
      pslverr_r <= psel && !penable && !pready_r && !addr_ok;
      if (psel && !penable && !pready_r)
        prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
      if (!is_idle)
        start_r <= 1'b0;
      if (drv_dis_r)
        zero_r <= 1'b0;
      if (psel && penable && pready_r && pwrite && paddr == mrs_pkg::OFS_CTRL) begin
        run_r <= pwdata[mrs_pkg::CTRL_RUN];
        start_r <= pwdata[mrs_pkg::CTRL_START];
        zero_r <= pwdata[mrs_pkg::CTRL_ZERO];
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign mem_o = '{memory_address_reg, wdata_r, bwp_r, drv_dis_r, io_sel_r};
  assign io_o = '{in_ctl_r, stb_a_r, stb_b_r, stb_c_r, skip_r};
  assign accum_write_window = win_r;
  assign effective_addr_phase = eap_r;
  assign call_marker_flag = call_r;

  // Window length in pclk cycles
  logic [7:0] win_len_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      win_len_r <= 8'h00;
    else
      win_len_r <= win_r ? win_len_r + 8'h01 : 8'h00;
  end

  a_exec_ma_load: assert property (@(posedge pclk) disable iff (!presetn)
    (step && state_r == mrs_pkg::MRS_EXEC && slot0 && nib_r == 2'h0)
    |=> memory_address_reg == $past(operand_shift_reg))
    else $error("address register missed effective address");
  a_load_restore: assert property (@(posedge pclk) disable iff (!presetn)
    (step && state_r == mrs_pkg::MRS_EXEC && slot0 && nib_r == 2'h3 && opc == mrs_pkg::OPC_LOAD)
    |=> bwp_r && wdata_r == operand_shift_reg)
    else $error("load word not restored");
  a_window_length: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(win_r) |-> win_len_r == 8'(mrs_pkg::WINDOW_CLK * CPU_DIV))
    else $error("write window length wrong");
  a_pc_increment: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == mrs_pkg::MRS_FETCH && ts_r == 2'h2) |-> program_counter == operand_shift_reg + 16'h0001)
    else $error("counter not incremented operand");
  a_eap_set: assert property (@(posedge pclk) disable iff (!presetn)
    (cyc_end && state_r == mrs_pkg::MRS_FETCH) |=> eap_r == $past(memref))
    else $error("address phase flag wrong");
  a_autoindex_hit: assert property (@(posedge pclk) disable iff (!presetn)
    (step && state_r == mrs_pkg::MRS_DEFER && slot0 && nib_r == 2'h3)
    |=> loop_r == ($past(operand_shift_reg[14:5]) == 10'h000 && $past(operand_shift_reg[4])))
    else $error("autoindex detection wrong");
  a_loop_stretch: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(loop_r) |-> (ts_r == 2'h0 && nib_r == 2'h0) ##1 (ts_r == 2'h0)[*8])
    else $error("slot zero not stretched");
  a_input_strobe: assert property (@(posedge pclk) disable iff (!presetn)
    (step && state_r == mrs_pkg::MRS_FETCH && ts_r == 2'h2 && nib_r == 2'h0 && opc == mrs_pkg::OPC_IN)
    |=> in_ctl_r && io_sel_r && (stb_a_r || stb_b_r || stb_c_r || skip_r))
    else $error("input strobe not started");
  a_input_buffer: assert property (@(posedge pclk) disable iff (!presetn)
    (step && state_r == mrs_pkg::MRS_EXEC && slot0 && nib_r == 2'h0 && opc == mrs_pkg::OPC_IN)
    |=> bwp_r && io_sel_r)
    else $error("input buffer write missing");
  a_zero_load: assert property (@(posedge pclk) disable iff (!presetn)
    (drv_dis_r && step) |=> operand_shift_reg == 16'h0000)
    else $error("operand not zeroed");
endmodule
`default_nettype wire

// ### verification/mrs_core_mem.sv
// Core memory and I/O bus model facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module mrs_core_mem (
  // Clock
  input wire logic pclk,
  // Sequencer side
  input wire mrs_pkg::mrs_mem_t mem_i,
  input wire logic [15:0] io_data,
  output logic [15:0] mem_rdata
);
  logic [15:0] word_r [0:255];
  initial begin
    for (int i = 0; i < 256; i++) begin
      word_r[i] = 16'h0000;
    end
  end
  // Disabled drivers leave the bus at zero
  assign mem_rdata = mem_i.memory_driver_disable ? 16'h0000 : word_r[mem_i.addr[7:0]];
  // Buffer write restores or stores; I/O bus taken when selected
  always @(posedge pclk) begin
    if (mem_i.buffer_write_pulse) begin
      word_r[mem_i.addr[7:0]] <= mem_i.io_bus_select ? io_data : mem_i.wdata;
    end
  end
endmodule
`default_nettype wire

// ### verification/mrs_sequencer_tb.sv
// Self-checking bench for the memory reference sequencer
`timescale 1ns/10ps
`default_nettype none
module mrs_sequencer_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [15:0] io_data = 16'h0000;
  logic [31:0] prdata;
  logic pready, pslverr, win, eaddr, call, err;
  logic [15:0] mem_rdata;
  mrs_pkg::mrs_mem_t mem_o;
  mrs_pkg::mrs_io_t io_o;
  int miscompares = 0;
  int check_count = 0;
  int win_cnt;
  logic clr = 1'b0;
  logic [6:0] seen;
  logic [31:0] rd;
  always #25 pclk = ~pclk;
  mrs_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_rdata(mem_rdata), .mem_o(mem_o), .io_o(io_o),
    .accum_write_window(win), .effective_addr_phase(eaddr), .call_marker_flag(call));
  mrs_core_mem u_mem (.pclk(pclk), .mem_i(mem_o), .io_data(io_data), .mem_rdata(mem_rdata));
  // Sticky record of pulses and window length
  always @(posedge pclk) begin
    if (clr) begin
      win_cnt <= 0;
      seen <= 7'h00;
    end else begin
      win_cnt <= win_cnt + int'(win);
      seen <= seen | {eaddr, call, mem_o.memory_driver_disable, io_o.input_strobe_c,
        io_o.input_strobe_b, io_o.input_strobe_a, io_o.skip_test};
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask
  task automatic clear_mon();
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
  endtask
  task automatic run_to_idle();
    int n;
    clear_mon();
    apb(1'b1, mrs_pkg::OFS_CTRL, 32'h00000001);
    n = 0;
    do begin
      apb(1'b0, mrs_pkg::OFS_STATUS, 32'h00000000);
      n++;
    end while (rd[3:0] !== 4'h1 && n < 400);
    if (n >= 400) begin
      miscompares++;
      stop_test();
    end
    repeat (30) @(posedge pclk);
  endtask
  task automatic t_load();
    u_mem.word_r[8'h00] = 16'h4040;
    u_mem.word_r[8'h40] = 16'h1234;
    run_to_idle();
    rchk(mrs_pkg::OFS_RESULT, 32'h00001234);
    chk({16'h0000, u_mem.word_r[8'h40]}, 32'h00001234);
    rchk(mrs_pkg::OFS_MADDR, 32'h00000040);
    rchk(mrs_pkg::OFS_PC, 32'h00000001);
    chk(32'(win_cnt), 32'h00000018);
    chk({31'h0, seen[6]}, 32'h00000001);
  endtask
  task automatic t_store();
    apb(1'b1, mrs_pkg::OFS_WREG0 + 8'h04, 32'h0000BEEF);
    u_mem.word_r[8'h01] = 16'h6841;
    run_to_idle();
    chk({16'h0000, u_mem.word_r[8'h41]}, 32'h0000BEEF);
    rchk(mrs_pkg::OFS_PC, 32'h00000002);
  endtask
  task automatic t_indirect();
    u_mem.word_r[8'h02] = 16'h0410;
    u_mem.word_r[8'h10] = 16'h0100;
    run_to_idle();
    chk({16'h0000, u_mem.word_r[8'h10]}, 32'h000000FF);
    rchk(mrs_pkg::OFS_PC, 32'h000000FF);
    apb(1'b1, mrs_pkg::OFS_PC, 32'h00000003);
    u_mem.word_r[8'h03] = 16'h2418;
    u_mem.word_r[8'h18] = 16'h0200;
    run_to_idle();
    chk({16'h0000, u_mem.word_r[8'h18]}, 32'h00000201);
    rchk(mrs_pkg::OFS_PC, 32'h00000201);
    rchk(mrs_pkg::OFS_WREG0 + 8'h0C, 32'h00000004);
    chk({31'h0, seen[5]}, 32'h00000001);
  endtask
  task automatic t_input();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, mrs_pkg::OFS_PC, 32'h00000020 + 32'(i));
      u_mem.word_r[8'h20 + 8'(i)] = 16'hC000 | 16'(i << 9);
      io_data <= 16'hA5A0 + 16'(i);
      run_to_idle();
      chk({31'h0, seen[i]}, 32'h00000001);
      rchk(mrs_pkg::OFS_RESULT, 32'h0000A5A0 + 32'(i));
    end
  endtask
  task automatic t_zero();
    clear_mon();
    apb(1'b1, mrs_pkg::OFS_CTRL, 32'h00000004);
    repeat (12) @(posedge pclk);
    rchk(mrs_pkg::OFS_OPERAND, 32'h00000000);
    chk({31'h0, seen[4]}, 32'h00000001);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(mrs_pkg::OFS_STATUS, 32'h00000001);
    apb(1'b0, 8'h40, 32'h00000000);
    chk({31'h0, err}, 32'h00000001);
    t_load();
    t_store();
    t_indirect();
    t_input();
    t_zero();
    stop_test();
  end
endmodule
`default_nettype wire
